/* rtl/tpu_attach_fsm.sv */
// Operation
// - idle source: no bus power, independent pull-ups, distinct value per pin.
// - idle source moves to attach wait when both pins show pull-down.
// - dual-role idle source goes idle sink after source phase or command.
// - attach wait keeps terminations; attaches after debounce with safe zero.
// - attach wait open pin: source to idle source, dual-role to idle sink.
// - attached source keeps distinct pull-ups, powers bus at advertised offer.
// - messaging allowed in attached sink, and in attached source at safe five, role source.
// - debug signals connected only after entering an attached state.
// - attached source open pin: source to idle source, dual-role idle sink.
// - bus power stops within power-off time after leaving attached source.
// - try source: no bus power, independent distinct pull-ups.
// - try source attaches after pull-downs persist for try debounce.
// - try source goes try-wait sink after try timeout without pull-downs.
// - try-wait sink: no bus power, pull-downs on both pins.
// - try-wait sink attaches as sink after debounce, no open, bus power.
// - try-wait sink back to idle sink on open or missing bus power.
// - offer pairs: default 3a/1a5, 1a5 1a5/default, 3a 3a/default.
// - dual-role sink attach wait enters try source after debounce and power.
// - idle sink enters sink attach wait on pull-ups on both pins.
// - attached sink returns to idle sink when bus power goes away.
`timescale 1ns/1ps
`default_nettype none

module tpu_attach_fsm #(
	parameter int ATTACH_DEB_CYC = tpu_pkg::TPU_ATTACH_DEB_CYC,
	parameter int TRY_DEB_CYC = tpu_pkg::TPU_TRY_DEB_CYC,
	parameter int TRY_TIMEOUT_CYC = tpu_pkg::TPU_TRY_TIMEOUT_CYC,
	parameter int DETACH_DEB_CYC = tpu_pkg::TPU_DETACH_DEB_CYC,
	parameter int SRC_PHASE_CYC = tpu_pkg::TPU_SRC_PHASE_CYC,
	parameter int SNK_PHASE_CYC = tpu_pkg::TPU_SNK_PHASE_CYC
) (
	input wire logic CLK,
	input wire logic RST_N,
	input wire tpu_pkg::tpu_role_e ROLE,
	input wire tpu_pkg::tpu_cc_pair_s CC_LEVEL,
	input wire tpu_pkg::tpu_vbus_s VBUS,
	input wire tpu_pkg::tpu_offer_e OFFER,
	input wire logic SWITCH_ROLE,
	output tpu_pkg::tpu_state_e STATE,
	output tpu_pkg::tpu_term_s TERM,
	output logic VBUS_EN,
	output logic DEBUG_CONNECT,
	output logic PD_ALLOWED,
	output logic PD_ROLE_SOURCE
);
	import tpu_pkg::*;

	// ---------------------------------------------------------------
	// decoded pin conditions
	// ---------------------------------------------------------------
	tpu_state_e state;
	tpu_state_e next_state;
	logic [TPU_CNT_W-1:0] timer;
	logic both_pd;
	logic any_open;
	logic both_pu;
	logic is_dual;
	logic entered;
	// dwell of the present pin condition, apart from the state timer
	logic [TPU_CNT_W-1:0] pd_cnt;
	logic [TPU_CNT_W-1:0] open_cnt;
	logic [TPU_CNT_W-1:0] att_deb;
	logic [TPU_CNT_W-1:0] try_deb;
	logic [TPU_CNT_W-1:0] try_to;
	logic [TPU_CNT_W-1:0] det_deb;
	logic [TPU_CNT_W-1:0] src_ph;
	logic [TPU_CNT_W-1:0] snk_ph;

	// programmable counts at counter width
	assign att_deb = TPU_CNT_W'(ATTACH_DEB_CYC);
	assign try_deb = TPU_CNT_W'(TRY_DEB_CYC);
	assign try_to = TPU_CNT_W'(TRY_TIMEOUT_CYC);
	assign det_deb = TPU_CNT_W'(DETACH_DEB_CYC);
	assign src_ph = TPU_CNT_W'(SRC_PHASE_CYC);
	assign snk_ph = TPU_CNT_W'(SNK_PHASE_CYC);

	// pin level classification
	assign both_pd = (CC_LEVEL.cc1 == TPU_CC_PULLDOWN) &&
		(CC_LEVEL.cc2 == TPU_CC_PULLDOWN);
	assign any_open = (CC_LEVEL.cc1 == TPU_CC_OPEN) ||
		(CC_LEVEL.cc2 == TPU_CC_OPEN);
	assign both_pu = (CC_LEVEL.cc1 inside {TPU_CC_PU_DEFAULT, TPU_CC_PU_1A5,
		TPU_CC_PU_3A}) && (CC_LEVEL.cc2 inside {TPU_CC_PU_DEFAULT,
		TPU_CC_PU_1A5, TPU_CC_PU_3A});
	assign is_dual = (ROLE == TPU_ROLE_DUAL);
	assign entered = (next_state != state);

	// ---------------------------------------------------------------
	// next state
	// ---------------------------------------------------------------
	always_comb begin
		next_state = state;
		case (state)
			TPU_IDLE_SOURCE: begin
				// the role pin outranks attach and toggling
				if (ROLE == TPU_ROLE_SINK) begin
					next_state = TPU_IDLE_SINK;
				end else if (both_pd) begin
					next_state = TPU_SOURCE_ATTACH_WAIT;
				end else if (is_dual && (SWITCH_ROLE || timer >= src_ph)) begin
					next_state = TPU_IDLE_SINK;
				end
			end
			TPU_SOURCE_ATTACH_WAIT: begin
				// timer restarts while the pull-downs are broken
				if (any_open) begin
					next_state = is_dual ? TPU_IDLE_SINK : TPU_IDLE_SOURCE;
				end else if (!both_pd) begin
					next_state = TPU_SOURCE_ATTACH_WAIT;
				end else if (timer >= att_deb && VBUS.safe_zero_level) begin
					next_state = TPU_ATTACHED_SOURCE;
				end
			end
			TPU_ATTACHED_SOURCE: begin
				// detach on either pin going open
				if (any_open) begin
					next_state = is_dual ? TPU_IDLE_SINK : TPU_IDLE_SOURCE;
				end
			end
			TPU_TRY_SOURCE: begin
				// late pull-downs must still persist for the full debounce
				if (both_pd && pd_cnt >= try_deb) begin
					next_state = TPU_ATTACHED_SOURCE;
				end else if (!both_pd && timer >= try_to) begin
					next_state = TPU_TRY_WAIT_SINK;
				end
			end
			TPU_TRY_WAIT_SINK: begin
				// an open pin is timed from when it opened
				if (any_open && open_cnt >= det_deb) begin
					next_state = TPU_IDLE_SINK;
				end else if (!any_open && VBUS.present && timer >= att_deb) begin
					next_state = TPU_ATTACHED_SINK;
				end else if (!VBUS.present && timer >= det_deb &&
					timer >= att_deb) begin
					next_state = TPU_IDLE_SINK;
				end
			end
			TPU_IDLE_SINK: begin
				// pull-downs on both pins while waiting for a source
				if (ROLE == TPU_ROLE_SOURCE) begin
					next_state = TPU_IDLE_SOURCE;
				end else if (both_pu) begin
					next_state = TPU_SINK_ATTACH_WAIT;
				end else if (is_dual && (SWITCH_ROLE || timer >= snk_ph)) begin
					next_state = TPU_IDLE_SOURCE;
				end
			end
			TPU_SINK_ATTACH_WAIT: begin
				// open time counted from the opening, not from entry
				if (any_open && open_cnt >= det_deb) begin
					next_state = is_dual ? TPU_IDLE_SOURCE : TPU_IDLE_SINK;
				end else if (!any_open && VBUS.present && timer >= att_deb) begin
					next_state = is_dual ? TPU_TRY_SOURCE : TPU_ATTACHED_SINK;
				end
			end
			TPU_ATTACHED_SINK: begin
				// leaves only on loss of bus power
				if (!VBUS.present) begin
					next_state = TPU_IDLE_SINK;
				end
			end
			default: begin
				next_state = TPU_IDLE_SOURCE;
			end
		endcase
	end

	// ---------------------------------------------------------------
	// state register
	// ---------------------------------------------------------------
	always_ff @(posedge CLK or negedge RST_N) begin
		if (!RST_N) begin
			state <= TPU_IDLE_SOURCE;
		end else begin
			state <= next_state;
		end
	end

	// dwell timer, restarts on entry and on a pull-down gap in source attach wait
	// saturates so a long dwell never wraps into a short one
	always_ff @(posedge CLK or negedge RST_N) begin
		if (!RST_N) begin
			timer <= TPU_CNT_ZERO;
		end else if (entered) begin
			timer <= TPU_CNT_ZERO;
		end else if (state == TPU_SOURCE_ATTACH_WAIT && !both_pd) begin
			timer <= TPU_CNT_ZERO;
		end else if (timer != '1) begin
			timer <= timer + 1'b1;
		end
	end

	// ---------------------------------------------------------------
	// pin condition counters
	// ---------------------------------------------------------------
	// a condition that shows up late in a state still gets its full
	// debounce; the state timer alone would credit the time before it
	// cycles with pull-downs on both pins, cleared on entry or a gap
	always_ff @(posedge CLK or negedge RST_N) begin
		if (!RST_N) begin
			pd_cnt <= TPU_CNT_ZERO;
		end else if (entered || !both_pd) begin
			pd_cnt <= TPU_CNT_ZERO;
		end else if (pd_cnt != '1) begin
			pd_cnt <= pd_cnt + 1'b1;
		end
	end

	// cycles with a pin open, cleared on entry or once both pins close
	always_ff @(posedge CLK or negedge RST_N) begin
		if (!RST_N) begin
			open_cnt <= TPU_CNT_ZERO;
		end else if (entered || !any_open) begin
			open_cnt <= TPU_CNT_ZERO;
		end else if (open_cnt != '1) begin
			open_cnt <= open_cnt + 1'b1;
		end
	end

	// ---------------------------------------------------------------
	// outputs, all registered from the next state, debug and messaging also from the present state
	// ---------------------------------------------------------------
	// pins change on the same edge as the state register
	always_ff @(posedge CLK or negedge RST_N) begin
		if (!RST_N) begin
			STATE <= TPU_IDLE_SOURCE;
			TERM <= '{pullup_en: 1'b1, pulldown_en: 1'b0,
				cc1_pu: TPU_PU_3A, cc2_pu: TPU_PU_1A5};
		end else begin
			STATE <= next_state;
			case (next_state)
				TPU_IDLE_SOURCE, TPU_SOURCE_ATTACH_WAIT, TPU_TRY_SOURCE: begin
					// distinct pull-ups per pin
					TERM <= '{pullup_en: 1'b1, pulldown_en: 1'b0,
						cc1_pu: TPU_PU_3A, cc2_pu: TPU_PU_1A5};
				end
				TPU_ATTACHED_SOURCE: begin
					TERM.pullup_en <= 1'b1;
					TERM.pulldown_en <= 1'b0;
					// offer pairs
					case (OFFER)
						TPU_OFFER_1A5: begin
							TERM.cc1_pu <= TPU_PU_1A5;
							TERM.cc2_pu <= TPU_PU_DEFAULT;
						end
						TPU_OFFER_3A: begin
							TERM.cc1_pu <= TPU_PU_3A;
							TERM.cc2_pu <= TPU_PU_DEFAULT;
						end
						default: begin
							TERM.cc1_pu <= TPU_PU_3A;
							TERM.cc2_pu <= TPU_PU_1A5;
						end
					endcase
				end
				default: begin
					// pull-downs on both pins
					TERM <= '{pullup_en: 1'b0, pulldown_en: 1'b1,
						cc1_pu: TPU_PU_DEFAULT, cc2_pu: TPU_PU_DEFAULT};
				end
			endcase
		end
	end

	// bus power only while attached as source
	// dropped on the exit edge itself, well inside the off time
	always_ff @(posedge CLK or negedge RST_N) begin
		if (!RST_N) begin
			VBUS_EN <= 1'b0;
		end else begin
			VBUS_EN <= (next_state == TPU_ATTACHED_SOURCE);
		end
	end

	// debug routing and messaging permission
	// both wait one cycle after entry so nothing precedes the attach
	always_ff @(posedge CLK or negedge RST_N) begin
		if (!RST_N) begin
			DEBUG_CONNECT <= 1'b0;
			PD_ALLOWED <= 1'b0;
			PD_ROLE_SOURCE <= 1'b0;
		end else begin
			DEBUG_CONNECT <= (state == TPU_ATTACHED_SOURCE &&
				next_state == TPU_ATTACHED_SOURCE) ||
				(state == TPU_ATTACHED_SINK && next_state == TPU_ATTACHED_SINK);
			PD_ALLOWED <= (state == TPU_ATTACHED_SOURCE &&
				next_state == TPU_ATTACHED_SOURCE && VBUS.safe_five_level) ||
				(state == TPU_ATTACHED_SINK && next_state == TPU_ATTACHED_SINK);
			PD_ROLE_SOURCE <= (next_state == TPU_ATTACHED_SOURCE);
		end
	end

endmodule // tpu_attach_fsm

`default_nettype wire

/* rtl/tpu_pkg.sv */
`default_nettype none
package tpu_pkg;

	// ---------------------------------------------------------------
	// probe roles
	// ---------------------------------------------------------------
	typedef enum logic [1:0] {
		TPU_ROLE_SOURCE,
		TPU_ROLE_SINK,
		TPU_ROLE_DUAL
	} tpu_role_e;

	// ---------------------------------------------------------------
	// classified level of one cc pin
	// ---------------------------------------------------------------
	typedef enum logic [2:0] {
		TPU_CC_OPEN,
		TPU_CC_PULLDOWN,
		TPU_CC_PU_DEFAULT,
		TPU_CC_PU_1A5,
		TPU_CC_PU_3A
	} tpu_cc_e;

	// ---------------------------------------------------------------
	// pull-up strength and current offer
	// ---------------------------------------------------------------
	typedef enum logic [1:0] {
		TPU_PU_DEFAULT,
		TPU_PU_1A5,
		TPU_PU_3A
	} tpu_pu_e;

	typedef enum logic [1:0] {
		TPU_OFFER_DEFAULT,
		TPU_OFFER_1A5,
		TPU_OFFER_3A
	} tpu_offer_e;

	// ---------------------------------------------------------------
	// connection states
	// ---------------------------------------------------------------
	typedef enum logic [3:0] {
		TPU_IDLE_SOURCE,
		TPU_SOURCE_ATTACH_WAIT,
		TPU_ATTACHED_SOURCE,
		TPU_TRY_SOURCE,
		TPU_TRY_WAIT_SINK,
		TPU_IDLE_SINK,
		TPU_SINK_ATTACH_WAIT,
		TPU_ATTACHED_SINK
	} tpu_state_e;

	// ---------------------------------------------------------------
	// cc pin pair and bus voltage flags
	// ---------------------------------------------------------------
	typedef struct packed {
		tpu_cc_e cc1;
		tpu_cc_e cc2;
	} tpu_cc_pair_s;

	typedef struct packed {
		logic safe_zero_level;
		logic safe_five_level;
		logic present;
	} tpu_vbus_s;

	// terminations driven on both pins
	typedef struct packed {
		logic pullup_en;
		logic pulldown_en;
		tpu_pu_e cc1_pu;
		tpu_pu_e cc2_pu;
	} tpu_term_s;

	// ---------------------------------------------------------------
	// timing: figures in microseconds, counts at 250 mhz
	// ---------------------------------------------------------------
	localparam int TPU_CLK_MHZ = 250;
	localparam int TPU_CNT_W = 32;
	localparam int TPU_ATTACH_DEB_US = 100;
	localparam int TPU_TRY_DEB_US = 10;
	localparam int TPU_TRY_TIMEOUT_US = 75;
	localparam int TPU_DETACH_DEB_US = 10;
	localparam int TPU_TOGGLE_US = 50;
	localparam int TPU_SRC_DUTY_PCT = 50;
	localparam int TPU_ATTACH_DEB_CYC = TPU_ATTACH_DEB_US * TPU_CLK_MHZ;
	localparam int TPU_TRY_DEB_CYC = TPU_TRY_DEB_US * TPU_CLK_MHZ;
	localparam int TPU_TRY_TIMEOUT_CYC = TPU_TRY_TIMEOUT_US * TPU_CLK_MHZ;
	localparam int TPU_DETACH_DEB_CYC = TPU_DETACH_DEB_US * TPU_CLK_MHZ;
	localparam int TPU_SRC_PHASE_CYC =
		TPU_TOGGLE_US * TPU_SRC_DUTY_PCT * TPU_CLK_MHZ / 100;
	localparam int TPU_SNK_PHASE_CYC =
		TPU_TOGGLE_US * TPU_CLK_MHZ - TPU_SRC_PHASE_CYC;

	// reset values
	localparam logic [TPU_CNT_W-1:0] TPU_CNT_ZERO = '0;

endpackage

`default_nettype wire

/* tb/tpu_sut_model.sv */
`timescale 1ns/1ps
`default_nettype none
// ----------
// far port: 0 open, 1 sink, 2 source, 3 one pin open
// ----------
module tpu_sut_model #(
	parameter int RAMP = 3,
	parameter int DEB = 4
) (
	input wire logic CLK,
	input wire logic RST_N,
	input wire logic [1:0] MODE,
	input wire logic VBUS_EN,
	input wire tpu_pkg::tpu_term_s TERM,
	output tpu_pkg::tpu_cc_pair_s CC_LEVEL,
	output tpu_pkg::tpu_vbus_s VBUS,
	output tpu_pkg::tpu_offer_e SUB
);
	import tpu_pkg::*;
	int lvl;
	int stb;
	tpu_offer_e adv;
	tpu_offer_e seen;
	// offer read from both probe pull-ups
	always_comb begin
		adv = TPU_OFFER_DEFAULT;
		if (TERM.pullup_en && TERM.cc2_pu == TPU_PU_DEFAULT) begin
			adv = TPU_OFFER_1A5;
			if (TERM.cc1_pu == TPU_PU_3A) adv = TPU_OFFER_3A;
		end
	end
	// far sink power sub-state, follows a stable offer only
	always_ff @(posedge CLK or negedge RST_N) begin
		if (!RST_N) begin
			seen <= TPU_OFFER_DEFAULT;
			stb <= 0;
			SUB <= TPU_OFFER_DEFAULT;
		end else if (MODE != 2'h1 || lvl == 0) begin
			seen <= TPU_OFFER_DEFAULT;
			stb <= 0;
			SUB <= TPU_OFFER_DEFAULT;
		end else if (adv != seen) begin
			seen <= adv;
			stb <= 0;
		end else if (stb < DEB) begin
			stb <= stb + 1;
		end else begin
			SUB <= seen;
		end
	end
	// bus voltage ramps with the probe supply
	always_ff @(posedge CLK or negedge RST_N) begin
		if (!RST_N) lvl <= 0;
		else if (VBUS_EN && lvl < RAMP) lvl <= lvl + 1;
		else if (!VBUS_EN && lvl > 0) lvl <= lvl - 1;
	end
	// terminations seen by the probe
	always_comb begin
		CC_LEVEL = '{TPU_CC_OPEN, TPU_CC_OPEN};
		VBUS = '{lvl == 0, lvl == RAMP, lvl > 0};
		case (MODE)
		2'h1: CC_LEVEL = '{TPU_CC_PULLDOWN, TPU_CC_PULLDOWN};
		2'h2: begin
			CC_LEVEL = '{TPU_CC_PU_DEFAULT, TPU_CC_PU_DEFAULT};
			VBUS = '{1'b0, 1'b1, 1'b1};
		end
		2'h3: CC_LEVEL.cc1 = TPU_CC_PULLDOWN;
		default: ;
		endcase
	end
endmodule // tpu_sut_model
`default_nettype wire

/* tb/tpu_attach_fsm_asserts.sv */
`timescale 1ns/1ps
`default_nettype none
// ----------
// port checker
// ----------
module tpu_attach_fsm_asserts #(
	parameter int ATTACH_DEB_CYC = 20,
	parameter int TRY_DEB_CYC = 10,
	parameter int TRY_TIMEOUT_CYC = 30
) (
	input wire logic CLK,
	input wire logic RST_N,
	input wire tpu_pkg::tpu_role_e ROLE,
	input wire tpu_pkg::tpu_cc_pair_s CC_LEVEL,
	input wire tpu_pkg::tpu_vbus_s VBUS,
	input wire tpu_pkg::tpu_state_e STATE,
	input wire tpu_pkg::tpu_term_s TERM,
	input wire logic VBUS_EN,
	input wire logic DEBUG_CONNECT,
	input wire logic PD_ALLOWED
);
	import tpu_pkg::*;
	logic pd2;
	logic op;
	int saw_cnt;
	int try_cnt;
	int tpd_cnt;
	// pin summaries
	assign pd2 = CC_LEVEL.cc1 == TPU_CC_PULLDOWN
		&& CC_LEVEL.cc2 == TPU_CC_PULLDOWN;
	assign op = CC_LEVEL.cc1 == TPU_CC_OPEN || CC_LEVEL.cc2 == TPU_CC_OPEN;
	// dwell counters
	always_ff @(posedge CLK or negedge RST_N) begin
		if (!RST_N) begin
			saw_cnt <= 0;
			try_cnt <= 0;
			tpd_cnt <= 0;
		end else begin
			saw_cnt <= (STATE == TPU_SOURCE_ATTACH_WAIT && pd2) ? saw_cnt + 1 : 0;
			try_cnt <= (STATE == TPU_TRY_SOURCE) ? try_cnt + 1 : 0;
			tpd_cnt <= (STATE == TPU_TRY_SOURCE && pd2) ? tpd_cnt + 1 : 0;
		end
	end
	default clocking @(posedge CLK); endclocking
	default disable iff (!RST_N);
	property p_idle_term;
		STATE == TPU_IDLE_SOURCE |-> TERM.pullup_en && !TERM.pulldown_en
			&& TERM.cc1_pu != TERM.cc2_pu;
	endproperty
	a_idle_term: assert property (p_idle_term)
		else $error("idle source terminations wrong");
	property p_vbus;
		VBUS_EN == (STATE == TPU_ATTACHED_SOURCE);
	endproperty
	a_vbus: assert property (p_vbus)
		else $error("bus power not tied to attached source");
	property p_trywait;
		STATE == TPU_TRY_WAIT_SINK |-> TERM.pulldown_en && !TERM.pullup_en;
	endproperty
	a_trywait: assert property (p_trywait)
		else $error("try wait terminations wrong");
	property p_rd_go;
		STATE == TPU_IDLE_SOURCE && pd2 && ROLE == TPU_ROLE_SOURCE
			|=> STATE == TPU_SOURCE_ATTACH_WAIT;
	endproperty
	a_rd_go: assert property (p_rd_go)
		else $error("pull-downs did not start attach wait");
	property p_open_src;
		STATE == TPU_ATTACHED_SOURCE && op && ROLE == TPU_ROLE_SOURCE
			|=> STATE == TPU_IDLE_SOURCE;
	endproperty
	a_open_src: assert property (p_open_src)
		else $error("open pin did not detach");
	property p_debug;
		DEBUG_CONNECT |-> $past(STATE) inside {TPU_ATTACHED_SOURCE,
			TPU_ATTACHED_SINK};
	endproperty
	a_debug: assert property (p_debug)
		else $error("debug connected while unattached");
	property p_attach_deb;
		STATE == TPU_ATTACHED_SOURCE && $past(STATE) == TPU_SOURCE_ATTACH_WAIT
			|-> $past(saw_cnt) >= ATTACH_DEB_CYC && $past(VBUS.safe_zero_level);
	endproperty
	a_attach_deb: assert property (p_attach_deb)
		else $error("attached before debounce");
	property p_try_deb;
		STATE == TPU_ATTACHED_SOURCE && $past(STATE) == TPU_TRY_SOURCE
			|-> $past(tpd_cnt) >= TRY_DEB_CYC;
	endproperty
	a_try_deb: assert property (p_try_deb)
		else $error("try source attached early");
	property p_try_to;
		STATE == TPU_TRY_WAIT_SINK && $past(STATE) == TPU_TRY_SOURCE
			|-> $past(try_cnt) >= TRY_TIMEOUT_CYC && !$past(pd2);
	endproperty
	a_try_to: assert property (p_try_to)
		else $error("try timeout too early");
	property p_try_term;
		STATE == TPU_TRY_SOURCE |-> TERM.pullup_en && !TERM.pulldown_en
			&& TERM.cc1_pu != TERM.cc2_pu && !VBUS_EN;
	endproperty
	a_try_term: assert property (p_try_term)
		else $error("try source terminations wrong");
	property p_pd_safe;
		PD_ALLOWED && STATE == TPU_ATTACHED_SOURCE
			|-> $past(VBUS.safe_five_level);
	endproperty
	a_pd_safe: assert property (p_pd_safe)
		else $error("messaging allowed before safe five");
	c_att_src: cover property (STATE == TPU_ATTACHED_SOURCE);
	c_try_att: cover property (STATE == TPU_ATTACHED_SOURCE
		&& $past(STATE) == TPU_TRY_SOURCE);
	c_try_wait: cover property (STATE == TPU_TRY_WAIT_SINK);
	c_att_snk: cover property (STATE == TPU_ATTACHED_SINK);
endmodule // tpu_attach_fsm_asserts
bind tpu_attach_fsm tpu_attach_fsm_asserts #(
	.ATTACH_DEB_CYC(ATTACH_DEB_CYC),
	.TRY_DEB_CYC(TRY_DEB_CYC),
	.TRY_TIMEOUT_CYC(TRY_TIMEOUT_CYC)
) u_chk (.CLK(CLK), .RST_N(RST_N), .ROLE(ROLE), .CC_LEVEL(CC_LEVEL),
	.VBUS(VBUS), .STATE(STATE), .TERM(TERM), .VBUS_EN(VBUS_EN),
	.DEBUG_CONNECT(DEBUG_CONNECT), .PD_ALLOWED(PD_ALLOWED));
`default_nettype wire

/* tb/tb_top.sv */
`timescale 1ns/1ps
`default_nettype none
`define CHK(a, e) begin checked++; if ((a) !== (e)) begin fail_count++; \
	$display("BAD t=%0t got=%0h exp=%0h", $time, (a), (e)); end end
// ----------
// bench
// ----------
module tb_top;
	import tpu_pkg::*;
	localparam int AD = 20;
	localparam int TD = 10;
	localparam int TT = 30;
	localparam int SP = 40;
	localparam int DD = 12;
	localparam int OD = 4;
	logic clk, rst_n, sw, vbus_en, dbg, pd_ok, pd_src;
	logic [1:0] mode;
	logic [31:0] seed = 32'h9b1214d1;
	tpu_role_e role;
	tpu_offer_e offer, o, sub;
	tpu_offer_e oq[$];
	tpu_cc_pair_s cc;
	tpu_vbus_s vbus;
	tpu_state_e state;
	tpu_term_s term;
	int fail_count, checked, n;
	tpu_attach_fsm #(.ATTACH_DEB_CYC(AD), .TRY_DEB_CYC(TD),
		.TRY_TIMEOUT_CYC(TT), .DETACH_DEB_CYC(DD), .SRC_PHASE_CYC(SP),
		.SNK_PHASE_CYC(SP)) DUT (.CLK(clk), .RST_N(rst_n), .ROLE(role),
		.CC_LEVEL(cc), .VBUS(vbus), .OFFER(offer), .SWITCH_ROLE(sw),
		.STATE(state), .TERM(term), .VBUS_EN(vbus_en),
		.DEBUG_CONNECT(dbg), .PD_ALLOWED(pd_ok), .PD_ROLE_SOURCE(pd_src));
	tpu_sut_model #(.DEB(OD)) u_sut (.CLK(clk), .RST_N(rst_n),
		.MODE(mode), .VBUS_EN(vbus_en), .TERM(term), .CC_LEVEL(cc),
		.VBUS(vbus), .SUB(sub));
	// pseudo random source
	function automatic logic [31:0] xs(input logic [31:0] x);
		x ^= x << 13;
		x ^= x >> 17;
		x ^= x << 5;
		return x;
	endfunction
	// pull-up pair for each offer
	function automatic logic [3:0] exp_pu(input tpu_offer_e v);
		case (v)
		TPU_OFFER_1A5: return {TPU_PU_1A5, TPU_PU_DEFAULT};
		TPU_OFFER_3A: return {TPU_PU_3A, TPU_PU_DEFAULT};
		default: return {TPU_PU_3A, TPU_PU_1A5};
		endcase
	endfunction
	initial begin
		clk = 0;
		forever #2 clk = ~clk;
	end
	task stop_test;
		$display("checks %0d fails %0d", checked, fail_count);
		if (fail_count == 0 && checked > 0) $display("RESULT: PASS");
		else $display("RESULT: FAIL");
		$finish;
	endtask
	// bounded wait for a state, cycles in n
	task automatic wt(input tpu_state_e s, input int lim);
		n = 0;
		while (state !== s) begin
			@(posedge clk);
			#1;
			n++;
			if (n > lim) begin
				fail_count++;
				$display("BAD t=%0t got=%0h exp=%0h", $time, state, s);
				stop_test;
			end
		end
	endtask
	task go(input logic [1:0] m);
		@(posedge clk) mode <= m;
	endtask
	task cyc(input int k);
		repeat (k) @(posedge clk);
		#1;
	endtask
	// main sequence
	initial begin
		rst_n = 0;
		role = TPU_ROLE_SOURCE;
		offer = TPU_OFFER_DEFAULT;
		sw = 0;
		mode = 0;
		repeat (2) @(posedge clk);
		rst_n <= 1;
		cyc(2);
		`CHK({state, vbus_en}, {TPU_IDLE_SOURCE, 1'b0})
		`CHK({term.cc1_pu, term.cc2_pu}, {TPU_PU_3A, TPU_PU_1A5})
		go(1);
		wt(TPU_SOURCE_ATTACH_WAIT, 2);
		wt(TPU_ATTACHED_SOURCE, AD + 5);
		`CHK(n, AD + 1)
		`CHK(vbus_en, 1'b1)
		cyc(1);
		`CHK(dbg, 1'b1)
		repeat (6) begin
			seed = xs(seed);
			o = tpu_offer_e'(seed % 3);
			oq.push_back(o);
			@(posedge clk) offer <= o;
			cyc(2);
			`CHK({term.cc1_pu, term.cc2_pu}, exp_pu(oq.pop_front()))
			cyc(OD + 1);
			`CHK(sub, o)
		end
		`CHK({pd_ok, pd_src}, 2'b11)
		go(0);
		cyc(1);
		`CHK({state, vbus_en}, {TPU_IDLE_SOURCE, 1'b0})
		$display("test source attach ends");
		for (int r = 0; r < 2; r++) begin
			@(posedge clk) role <= r ? TPU_ROLE_DUAL : TPU_ROLE_SOURCE;
			mode <= 1;
			wt(TPU_SOURCE_ATTACH_WAIT, 3);
			cyc(5);
			go(3);
			cyc(1);
			`CHK(state, r ? TPU_IDLE_SINK : TPU_IDLE_SOURCE)
		end
		go(0);
		wt(TPU_IDLE_SOURCE, SP + 5);
		wt(TPU_IDLE_SINK, SP + 5);
		`CHK(n >= SP && n <= SP + 2, 1'b1)
		wt(TPU_IDLE_SOURCE, SP + 5);
		@(posedge clk) sw <= 1;
		@(posedge clk) sw <= 0;
		#1;
		`CHK(state, TPU_IDLE_SINK)
		$display("test toggle ends");
		go(2);
		wt(TPU_SINK_ATTACH_WAIT, SP + 5);
		wt(TPU_TRY_SOURCE, AD + 5);
		`CHK(n, AD + 1)
		wt(TPU_TRY_WAIT_SINK, TT + 5);
		`CHK(n, TT + 1)
		`CHK({term.pulldown_en, vbus_en}, 2'b10)
		wt(TPU_ATTACHED_SINK, AD + 5);
		`CHK(n, AD + 1)
		cyc(1);
		`CHK(dbg, 1'b1)
		go(0);
		wt(TPU_IDLE_SINK, 3);
		$display("test sink path ends");
		go(2);
		wt(TPU_TRY_SOURCE, 2 * SP + 2 * AD);
		cyc(5);
		go(1);
		wt(TPU_ATTACHED_SOURCE, TD + 5);
		`CHK(n >= TD && n <= TD + 2, 1'b1)
		go(0);
		cyc(1);
		`CHK(state, TPU_IDLE_SINK)
		go(2);
		wt(TPU_TRY_WAIT_SINK, 2 * SP + 2 * AD + TT);
		go(3);
		wt(TPU_IDLE_SINK, AD + 5);
		`CHK(n, DD + 1)
		$display("test try source ends");
		stop_test;
	end
endmodule // tb_top
`default_nettype wire
